// file: inc/itc_pkg.sv
// Constants, field layout and state type shared by the interval timer clock block.
package itc_pkg;
	// ==========================================================
	// Special-function-register offsets
	// ==========================================================
	localparam logic [7:0] OFF_CTL = 8'hA1;
	localparam logic [7:0] OFF_FRAC = 8'hA2;
	localparam logic [7:0] OFF_SEC = 8'hA3;
	localparam logic [7:0] OFF_MIN = 8'hA4;
	localparam logic [7:0] OFF_HOUR = 8'hA5;
	localparam logic [7:0] OFF_CMP = 8'hA6;

	// ==========================================================
	// Control register bit positions
	// ==========================================================
	localparam int BIT_RSVD = 7;
	localparam int BIT_TFH = 6;
	localparam int BIT_TS_HI = 5;
	localparam int BIT_TS_LO = 4;
	localparam int BIT_SINGLE = 3;
	localparam int BIT_FLAG = 2;
	localparam int BIT_INTERVAL_ENABLE = 1;
	localparam int BIT_TIME_CLOCK_ENABLE = 0;

	// ==========================================================
	// Counter chain indices and limits
	// ==========================================================
	localparam int NUM_TIME = 4;
	localparam int IDX_FRAC = 0;
	localparam int IDX_SEC = 1;
	localparam int IDX_MIN = 2;
	localparam int IDX_HOUR = 3;
	localparam logic [7:0] FRAC_MAX = 8'h7F;
	localparam logic [7:0] SEC_MAX = 8'h3B;
	localparam logic [7:0] MIN_MAX = 8'h3B;
	localparam logic [7:0] HOUR_MAX_24 = 8'h17;
	localparam logic [7:0] HOUR_MAX_FULL = 8'hFF;
	localparam logic [7:0] RESET_VAL = 8'h00;

	// ==========================================================
	// Timebase: 32.768 kHz input divided down to 128 Hz
	// ==========================================================
	localparam int TIMEBASE_HZ = 32768;
	localparam int FRAC_HZ = 128;
	localparam logic [7:0] PRESCALE_LAST = 8'(TIMEBASE_HZ / FRAC_HZ - 1);

	// Interval timebase select codes.
	typedef enum logic [1:0] {
		TS_FRAC,
		TS_SEC,
		TS_MIN,
		TS_HOUR
	} itc_ts_t;

	// Whole state of the top module.
	typedef struct packed {
		logic twenty_four_hour_select;
		logic [1:0] ts;
		logic single;
		logic flag;
		logic interval_enable;
		logic time_clock_enable;
		logic [7:0] compare;
		logic [NUM_TIME-1:0][7:0] shadow;
		logic [7:0] ivl_cnt;
		logic [7:0] prescale;
		logic tb_prev;
		logic [7:0] rdata;
	} itc_state_t;

	// Counter state of one wrapping counter.
	typedef struct packed {
		logic [7:0] count;
	} itc_cnt_state_t;
endpackage

// file: rtl/itc_wrap_counter.sv
// One 8-bit time counter that wraps at a programmable limit and reports its carry.
`timescale 1ns/100ps
module itc_wrap_counter import itc_pkg::*; (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic inc_i,
	input wire logic load_i,
	input wire logic [7:0] load_val_i,
	input wire logic [7:0] max_i,
	output logic [7:0] count_o,
	output logic wrap_o
);
	itc_cnt_state_t st;
	itc_cnt_state_t next_st;

	// Carry is suppressed during a load, so a write never ripples into the next stage.
	assign wrap_o = inc_i && !load_i && (st.count == max_i);
	assign count_o = st.count;

	// Load wins over counting; a value beyond the limit runs on to 255 and then 0 without a carry.
	always_comb begin
		next_st = st;
		if (load_i) begin
			next_st.count = load_val_i;
		end else if (wrap_o) begin
			next_st.count = RESET_VAL;
		end else if (inc_i) begin
			next_st.count = st.count + 8'h01;
		end
	end

	// State register.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule // itc_wrap_counter

// file: rtl/itc_interval_timer_clock.sv
// Time-of-day counter chain with interval timer, reached over the special-function-register port.
`timescale 1ns/100ps
// ==========================================================
// Overview of operation
// - Twenty-four-hour select set wraps hours after 23, else after 255.
// - Timebase field picks interval rate: 1/128 s, seconds, minutes or hours.
// - With single interval set, a timeout clears interval enable.
// - With single interval clear, each timeout reloads and restarts the interval counter.
// - Interval flag sets on counter matching compare and stays until software clears it.
// - A set flag requests an interrupt when enabled; compare accepts 0 to 255.
// - Interval counter runs only while interval enable is one.
// - Time clock enable gates the timebase to every counter.
// - Clearing time clock enable stops the clock and restores last written values.
// - Fraction counts 0 to 127 at 128 Hz, carrying into seconds.
// - Seconds count 0 to 59, carrying into minutes.
// - Minutes count 0 to 59, carrying into hours.
// - Hours advance once per hour and wrap to zero with no carry.
// - The chain runs from the 32.768 kHz timebase, also in power-down.
// - An enabled interval match in power-down wakes the device into its vector.
// ==========================================================
module itc_interval_timer_clock import itc_pkg::*; (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic tick32k_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_wr_i,
	input wire logic irq_en_i,
	input wire logic pwrdn_i,
	output logic [7:0] sfr_rdata_o,
	output logic sfr_hit_o,
	output logic irq_o,
	output logic wake_o
);
	itc_state_t st;
	itc_state_t next_st;
	logic [NUM_TIME-1:0][7:0] cnt;
	logic [NUM_TIME-1:0][7:0] load_val;
	logic [NUM_TIME-1:0][7:0] cnt_max;
	logic [NUM_TIME-1:0] wrap;
	logic [NUM_TIME-1:0] inc;
	logic [NUM_TIME-1:0] load;
	logic [NUM_TIME-1:0] time_wr;
	logic tb_edge;
	logic frac_tick;
	logic sel_evt;
	logic timeout;
	logic ctl_wr;
	logic cmp_wr;
	logic [7:0] ivl_next;

	// ==========================================================
	// Timebase and decode
	// ==========================================================
	// The 32.768 kHz input is taken as synchronous; a rising edge is one timebase period.
	// Nothing here looks at power-down, so the chain keeps time while the core sleeps.
	assign tb_edge = tick32k_i && !st.tb_prev;
	assign frac_tick = st.time_clock_enable && tb_edge && (st.prescale == PRESCALE_LAST);
	assign ctl_wr = sfr_wr_i && (sfr_addr_i == OFF_CTL);
	assign cmp_wr = sfr_wr_i && (sfr_addr_i == OFF_CMP);
	assign sfr_hit_o = (sfr_addr_i >= OFF_CTL) && (sfr_addr_i <= OFF_CMP);

	// ==========================================================
	// Time counter chain
	// ==========================================================
	// Each stage is fed by the carry of the one below; the fraction stage by the 128 Hz tick.
	// While the clock is off, every stage is reloaded from its shadow each cycle.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_TIME; gi++) begin : g_time
			if (gi == IDX_FRAC) begin : g_first
				assign inc[gi] = frac_tick;
			end else begin : g_next
				assign inc[gi] = wrap[gi-1];
			end
			if (gi == IDX_HOUR) begin : g_hour
				assign cnt_max[gi] = st.twenty_four_hour_select ? HOUR_MAX_24 : HOUR_MAX_FULL;
			end else if (gi == IDX_FRAC) begin : g_frac
				assign cnt_max[gi] = FRAC_MAX;
			end else if (gi == IDX_SEC) begin : g_sec
				assign cnt_max[gi] = SEC_MAX;
			end else begin : g_min
				assign cnt_max[gi] = MIN_MAX;
			end
			assign time_wr[gi] = sfr_wr_i && (sfr_addr_i == 8'(OFF_FRAC + 8'(gi)));
			assign load[gi] = time_wr[gi] || !st.time_clock_enable;
			assign load_val[gi] = time_wr[gi] ? sfr_wdata_i : st.shadow[gi];
			itc_wrap_counter u_cnt (
				.clk_i(clk_i),
				.rstn_i(rstn_i),
				.inc_i(inc[gi]),
				.load_i(load[gi]),
				.load_val_i(load_val[gi]),
				.max_i(cnt_max[gi]),
				.count_o(cnt[gi]),
				.wrap_o(wrap[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Interval counter
	// ==========================================================
	// The selected stage's advance clocks the interval counter.
	assign sel_evt = inc[st.ts];
	assign ivl_next = st.ivl_cnt + 8'h01;
	// Match is judged on the value being counted into, so compare 0 times out after 256 steps.
	assign timeout = st.interval_enable && sel_evt && (ivl_next == st.compare);

	// Interrupt request follows the sticky flag while the controller enables it.
	assign irq_o = st.flag && irq_en_i;
	// Wake-up is the same request seen while the core is powered down.
	assign wake_o = irq_o && pwrdn_i;
	assign sfr_rdata_o = st.rdata;

	// ==========================================================
	// Next-state logic
	// ==========================================================
	// Software writes are applied first; hardware events then override, so a timeout's flag set and enable clear win.
	always_comb begin
		next_st = st;
		next_st.tb_prev = tick32k_i;

		// Prescaler is held at zero while the clock is off so restarting is phase-aligned.
		if (!st.time_clock_enable) begin
			next_st.prescale = RESET_VAL;
		end else if (tb_edge) begin
			if (st.prescale == PRESCALE_LAST) begin
				next_st.prescale = RESET_VAL;
			end else begin
				next_st.prescale = st.prescale + 8'h01;
			end
		end

		// Shadows remember the last value software wrote to each time register.
		for (int i = 0; i < NUM_TIME; i++) begin
			if (time_wr[i]) begin
				next_st.shadow[i] = sfr_wdata_i;
			end
		end

		if (cmp_wr) begin
			next_st.compare = sfr_wdata_i;
		end

		// Reserved bit 7 has no storage at all.
		if (ctl_wr) begin
			next_st.twenty_four_hour_select = sfr_wdata_i[BIT_TFH];
			next_st.ts = sfr_wdata_i[BIT_TS_HI:BIT_TS_LO];
			next_st.single = sfr_wdata_i[BIT_SINGLE];
			next_st.flag = sfr_wdata_i[BIT_FLAG];
			next_st.interval_enable = sfr_wdata_i[BIT_INTERVAL_ENABLE];
			next_st.time_clock_enable = sfr_wdata_i[BIT_TIME_CLOCK_ENABLE];
		end

		// Counter sits at zero while disabled, so it starts from zero when enabled.
		if (!st.interval_enable) begin
			next_st.ivl_cnt = RESET_VAL;
		end else if (timeout) begin
			next_st.ivl_cnt = RESET_VAL;
		end else if (sel_evt) begin
			next_st.ivl_cnt = ivl_next;
		end

		// A timeout beats a simultaneous software write of the flag, and of the enable when single interval is set.
		if (timeout) begin
			next_st.flag = 1'b1;
			if (st.single) begin
				next_st.interval_enable = 1'b0;
			end
		end

		// Read data is registered from the address presented this cycle.
		next_st.rdata = RESET_VAL;
		if (sfr_addr_i == OFF_CTL) begin
			next_st.rdata = {1'b0, st.twenty_four_hour_select, st.ts, st.single, st.flag, st.interval_enable, st.time_clock_enable};
		end else if (sfr_addr_i == OFF_CMP) begin
			next_st.rdata = st.compare;
		end else begin
			for (int i = 0; i < NUM_TIME; i++) begin
				if (sfr_addr_i == 8'(OFF_FRAC + 8'(i))) begin
					next_st.rdata = cnt[i];
				end
			end
		end
	end

	// State register.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	sequence s_timeout;
		timeout && !ctl_wr;
	endsequence

	sequence s_sec_step;
		st.interval_enable && !timeout && st.ts == TS_SEC && inc[IDX_SEC];
	endsequence

	property p_wrap(int i, logic [7:0] m);
		(inc[i] && !load[i] && cnt[i] == m) |-> wrap[i] ##1 cnt[i] == RESET_VAL;
	endproperty

	a_hour_wrap_24: assert property (st.twenty_four_hour_select && inc[IDX_HOUR] && !load[IDX_HOUR] && cnt[IDX_HOUR] == HOUR_MAX_24
		|=> cnt[IDX_HOUR] == RESET_VAL) else $error("hour did not wrap after 23");
	a_hour_run_255: assert property (!st.twenty_four_hour_select && inc[IDX_HOUR] && !load[IDX_HOUR] && cnt[IDX_HOUR] == HOUR_MAX_24
		|=> cnt[IDX_HOUR] == 8'(HOUR_MAX_24 + 8'h01)) else $error("hour wrapped early");
	a_timebase_sec: assert property (s_sec_step |=> st.ivl_cnt == 8'($past(st.ivl_cnt) + 8'h01))
		else $error("interval did not step on seconds");
	a_single_stop: assert property (s_timeout ##0 st.single |=> !st.interval_enable && st.ivl_cnt == RESET_VAL)
		else $error("single interval did not stop");
	a_periodic_reload: assert property (s_timeout ##0 !st.single |=> st.interval_enable && st.ivl_cnt == RESET_VAL)
		else $error("periodic interval did not reload");
	a_flag_sticky: assert property (timeout ##1 !ctl_wr [*2] |=> st.flag)
		else $error("interval flag lost");
	a_irq_request: assert property (timeout ##1 irq_en_i |-> irq_o)
		else $error("no interrupt request after match");
	a_ivl_hold: assert property (!st.interval_enable |=> st.ivl_cnt == RESET_VAL)
		else $error("interval counter ran while disabled");
	a_clock_gate: assert property ((!st.time_clock_enable) [*2] |-> st.prescale == RESET_VAL && inc == '0)
		else $error("counters advanced with clock off");
	a_time_restore: assert property (!st.time_clock_enable |=> cnt == st.shadow)
		else $error("time registers not restored");
	a_frac_wrap: assert property (p_wrap(IDX_FRAC, FRAC_MAX))
		else $error("fraction did not wrap at 127");
	a_sec_wrap: assert property (p_wrap(IDX_SEC, SEC_MAX))
		else $error("seconds did not wrap at 59");
	a_min_wrap: assert property (p_wrap(IDX_MIN, MIN_MAX))
		else $error("minutes did not wrap at 59");
	a_prescale_run: assert property (st.time_clock_enable && tb_edge && st.prescale != PRESCALE_LAST
		|=> st.prescale == 8'($past(st.prescale) + 8'h01)) else $error("prescaler stalled");
	a_wake_pd: assert property (timeout ##1 (irq_en_i && pwrdn_i) |-> wake_o)
		else $error("no wake on match in power-down");
	a_rsvd_zero: assert property (sfr_addr_i == OFF_CTL |=> !sfr_rdata_o[BIT_RSVD])
		else $error("reserved control bit read as one");
endmodule // itc_interval_timer_clock

// file: bench/tb_top.sv
// Self-checking testbench for the interval timer clock block.
`timescale 1ns/100ps
module tb_top import itc_pkg::*;;
	// ==========================================================
	// Stimulus and observation signals
	// ==========================================================
	// One fraction step takes 256 timebase edges, with one edge every two cycles.
	localparam int STEP = 512;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic tick32k_i = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic irq_en = 1'b0;
	logic pwrdn = 1'b0;
	logic [7:0] rdata;
	logic hit;
	logic irq;
	logic wake;
	int mismatches = 0;
	int compares = 0;

	itc_interval_timer_clock dut (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.tick32k_i(tick32k_i),
		.sfr_addr_i(addr),
		.sfr_wdata_i(wdata),
		.sfr_wr_i(wr),
		.irq_en_i(irq_en),
		.pwrdn_i(pwrdn),
		.sfr_rdata_o(rdata),
		.sfr_hit_o(hit),
		.irq_o(irq),
		.wake_o(wake)
	);

	// ==========================================================
	// Clock and timebase
	// ==========================================================
	// The timebase is toggled at the falling edge so it is settled when sampled.
	always #50 clk_i = ~clk_i;
	always @(negedge clk_i) tick32k_i <= ~tick32k_i;

	// ==========================================================
	// Access and checking tasks
	// ==========================================================
	// Every task starts and ends just after a falling edge.
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// An idle cycle follows each write so the strobe never rises in the step it fell.
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk_i);
		wr = 1'b0;
		@(negedge clk_i);
	endtask

	// Read data is registered, so it is valid one edge after the address is taken.
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		addr = a;
		@(negedge clk_i);
		chk(rdata, exp);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Loads the chain, runs one fraction step, then stops and expects the loaded fraction and hour back.
	task automatic run_chain(input logic t24, input logic [7:0] f, s, m, h, ef, es, em, eh);
		wr_reg(OFF_CTL, 8'h00);
		wr_reg(OFF_FRAC, f);
		wr_reg(OFF_SEC, s);
		wr_reg(OFF_MIN, m);
		wr_reg(OFF_HOUR, h);
		wr_reg(OFF_CTL, {1'b0, t24, 6'h01});
		wait_cyc(STEP + 8);
		rd_chk(OFF_FRAC, ef);
		rd_chk(OFF_SEC, es);
		rd_chk(OFF_MIN, em);
		rd_chk(OFF_HOUR, eh);
		wr_reg(OFF_CTL, {1'b0, t24, 6'h00});
		rd_chk(OFF_FRAC, f);
		rd_chk(OFF_HOUR, h);
		wait_cyc(STEP + 8);
		rd_chk(OFF_FRAC, f);
	endtask

	// Single interval on timebase k; with p set the selected stage gets no carry.
	task automatic ivl(input logic [1:0] k, input logic p);
		int lvl;
		lvl = int'(k) - int'(p);
		wr_reg(OFF_CTL, 8'h00);
		wr_reg(OFF_FRAC, (lvl >= 1) ? 8'h7F : 8'h00);
		wr_reg(OFF_SEC, (lvl >= 2) ? 8'h3B : 8'h00);
		wr_reg(OFF_MIN, (lvl >= 3) ? 8'h3B : 8'h00);
		wr_reg(OFF_CMP, 8'h01);
		wr_reg(OFF_CTL, {2'b01, k, 4'b1011});
		wait_cyc(STEP + 8);
		rd_chk(OFF_CTL, {2'b01, k, 1'b1, ~p, p, 1'b1});
	endtask

	// ==========================================================
	// Hang guard
	// ==========================================================
	initial begin
		wait_cyc(90000);
		mismatches++;
		$display("CHECK FAILED at %0t: run did not finish in time", $time);
		end_sim();
	end

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		wait_cyc(3);
		rstn_i = 1'b1;
		// Reset values, map decode and the reserved control bit.
		for (int i = 0; i < 6; i++) begin
			rd_chk(OFF_CTL + 8'(i), 8'h00);
			chk({7'h00, hit}, 8'h01);
		end
		rd_chk(8'hA0, 8'h00);
		chk({7'h00, hit}, 8'h00);
		wr_reg(OFF_CTL, 8'h80);
		rd_chk(OFF_CTL, 8'h00);
		wr_reg(OFF_CMP, 8'hFF);
		rd_chk(OFF_CMP, 8'hFF);
		$display("test registers done");
		// Counter chain carries and hour wrap in both modes.
		run_chain(1'b1, 8'h7F, 8'h3B, 8'h3B, 8'h17, 8'h00, 8'h00, 8'h00, 8'h00);
		run_chain(1'b0, 8'h7F, 8'h3B, 8'h3B, 8'h17, 8'h00, 8'h00, 8'h00, 8'h18);
		run_chain(1'b0, 8'h7F, 8'h3B, 8'h3B, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00);
		run_chain(1'b1, 8'h0A, 8'h3A, 8'h03, 8'h07, 8'h0B, 8'h3A, 8'h03, 8'h07);
		run_chain(1'b1, 8'h7F, 8'h3A, 8'h3B, 8'h05, 8'h00, 8'h3B, 8'h3B, 8'h05);
		$display("test chain done");
		// Every timebase code with a carry into the selected stage, and codes 1 to 3 also without one.
		for (int k = 0; k < 4; k++) begin
			for (int p = 0; p < 2; p++) begin
				if (k > 0 || p == 0)
					ivl(2'(k), 1'(p));
			end
		end
		$display("test timebase done");
		// Interval disabled: no match while the clock runs.
		wr_reg(OFF_CTL, 8'h00);
		wr_reg(OFF_CMP, 8'h01);
		wr_reg(OFF_CTL, 8'h41);
		wait_cyc(STEP + 8);
		rd_chk(OFF_CTL, 8'h41);
		// Periodic mode with compare two, then interrupt and wake outputs.
		wr_reg(OFF_CTL, 8'h00);
		wr_reg(OFF_CMP, 8'h02);
		wr_reg(OFF_CTL, 8'h43);
		wait_cyc(STEP + 8);
		rd_chk(OFF_CTL, 8'h43);
		wait_cyc(STEP);
		rd_chk(OFF_CTL, 8'h47);
		irq_en = 1'b1;
		@(negedge clk_i);
		chk({7'h00, irq}, 8'h01);
		chk({7'h00, wake}, 8'h00);
		pwrdn = 1'b1;
		@(negedge clk_i);
		chk({7'h00, wake}, 8'h01);
		wait_cyc(4);
		rd_chk(OFF_CTL, 8'h47);
		wr_reg(OFF_CTL, 8'h43);
		chk({7'h00, irq}, 8'h00);
		chk({7'h00, wake}, 8'h00);
		pwrdn = 1'b0;
		wait_cyc(STEP - 16);
		rd_chk(OFF_CTL, 8'h43);
		wait_cyc(STEP);
		rd_chk(OFF_CTL, 8'h47);
		irq_en = 1'b0;
		@(negedge clk_i);
		chk({7'h00, irq}, 8'h00);
		$display("test interval done");
		end_sim();
	end
endmodule // tb_top
